//--- hw/spmc_chg_if.sv
// handshake between the register bank and the mode change sequencer
// assumes both ends run on the core clock
interface spmc_chg_if;
    logic start;
    logic use_reset;
    logic busy;
    logic started;
    logic done;
    logic port_reset;

    modport bank (output start, output use_reset,
                  input busy, input started, input done, input port_reset);
    modport seq (input start, input use_reset,
                 output busy, output started, output done, output port_reset);
endinterface

//--- hw/spmc_defines.svh
// offsets, field positions, reset values and timing counts of the port mode block
// assumes a 20 MHz core clock and byte addressing on an 8-bit apb address
`ifndef SPMC_DEFINES_SVH
`define SPMC_DEFINES_SVH

// register byte offsets
`define SPMC_OFF_CTL 8'h00
`define SPMC_OFF_STS 8'h04
`define SPMC_OFF_IRQ_EN 8'h08
`define SPMC_OFF_IRQ_CLR 8'h0C

// control field positions
`define SPMC_CTL_MODE_LSB 0
`define SPMC_CTL_PART_LSB 4
`define SPMC_CTL_DEV_LSB 10
`define SPMC_CTL_ACT_LSB 16
`define SPMC_CTL_SPARE_LSB 19

// status field positions
`define SPMC_STS_STARTED 0
`define SPMC_STS_DONE 1
`define SPMC_STS_LINK_UP 4
`define SPMC_STS_MODE_LSB 6
`define SPMC_STS_PART_LSB 10
`define SPMC_STS_DEV_LSB 16

// reset values
`define SPMC_ACT_RESET_VAL 2'h1
`define SPMC_PART_RESET_VAL 4'h0

// port reset pulse length
`define SPMC_CLK_PERIOD_NS 50
`define SPMC_RST_TIME_NS 1000
`define SPMC_RST_CYC ((`SPMC_RST_TIME_NS + `SPMC_CLK_PERIOD_NS - 1) / `SPMC_CLK_PERIOD_NS)

`endif

//--- hw/spmc_evt.sv
// sticky event flags with per-bit clear; a set in the clear cycle wins
// assumes set and clear are one-cycle pulses on the core clock
module spmc_evt (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [1:0] i_set,
    input wire logic [1:0] i_clr,
    output logic [1:0] o_flags
);
    // one sticky flop per event
    for (genvar g = 0; g < 2; g++) begin : g_flag
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                o_flags[g] <= 1'b0;
            end else if (i_ce) begin
                if (i_set[g]) o_flags[g] <= 1'b1;
                else if (i_clr[g]) o_flags[g] <= 1'b0;
            end
        end
    end
endmodule // spmc_evt

//--- hw/spmc_pkg.sv
// types shared by the port mode control block
// assumes nothing beyond a systemverilog compiler
package spmc_pkg;

    // port operating modes, codes above unattached are reserved
    typedef enum logic [2:0] {
        SPMC_MODE_DISABLED = 3'h0,
        SPMC_MODE_DOWNSTREAM = 3'h1,
        SPMC_MODE_UPSTREAM = 3'h2,
        SPMC_MODE_NT_EP = 3'h3,
        SPMC_MODE_UP_NT = 3'h4,
        SPMC_MODE_UNATTACHED = 3'h5
    } spmc_mode_t;

    // mode change action codes
    typedef enum logic [1:0] {
        SPMC_ACT_KEEP = 2'h0,
        SPMC_ACT_RESET = 2'h1
    } spmc_act_t;

    // mode change sequencer states, one-hot
    typedef enum logic [3:0] {
        SPMC_SEQ_IDLE = 4'b0001,
        SPMC_SEQ_START = 4'b0010,
        SPMC_SEQ_RESET = 4'b0100,
        SPMC_SEQ_DONE = 4'b1000
    } spmc_seq_t;

endpackage

//--- hw/spmc_port_ctrl.sv
// per-port mode control and status registers behind an apb slave
// assumes straps may change freely but settle for at least five core clock
// cycles while reset is high, since they pass a three flop synchroniser,
// and link and partition status come from logic on the same clock
//
// Behaviour
// RULE_01 - the mode field in bits 2:0 selects disabled, downstream, upstream, nt endpoint, upstream with nt endpoint or unattached; codes above 5 are reserved.
// RULE_02 - after reset the mode field holds a value derived from the boot switch mode, not a constant.
// RULE_03 - in the four operational modes the partition field in bits 7:4 picks the partition the port joins.
// RULE_04 - while disabled or unattached the partition field has no effect on the port.
// RULE_05 - as a downstream port the field in bits 14:10 gives the port device number.
// RULE_06 - in any other mode the device number field is ignored.
// RULE_07 - after reset the device number field holds this port's own number.
// RULE_08 - with action 1 in bits 17:16 a mode change resets the port like a fundamental reset.
// RULE_09 - with action 0 a mode change keeps the port state; other action codes are reserved.
// RULE_10 - the action field resets to 1.
// RULE_11 - status bit 0 is set when a change begins, resets to zero and is cleared by writing one.
// RULE_12 - status bit 1 is set when a change finishes, resets to zero and is cleared by writing one.
// RULE_13 - the status mode field shows the mode in effect, lagging the control, and disabled when the partition is.
// RULE_14 - a write altering mode, partition or device number starts a change with its action and both flags.
// RULE_15 - reserved read-only bits read zero and ignore writes.
//
// Chosen here: register access over APB and the placing of the registers.
`include "spmc_defines.svh"

module spmc_port_ctrl
    import spmc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [3:0] i_boot_switch_mode,
    input wire logic [3:0] i_port_number,
    input wire logic i_link_up,
    input wire logic i_partition_disabled,
    output logic [2:0] o_port_mode,
    output logic [3:0] o_partition,
    output logic o_partition_valid,
    output logic [4:0] o_device_number,
    output logic o_device_number_valid,
    output logic o_port_reset,
    output logic o_irq
);
    spmc_chg_if chg ();

    // control register fields
    logic [2:0] ctl_mode_ff;
    logic [3:0] ctl_part_ff;
    logic [4:0] ctl_dev_ff;
    logic [1:0] ctl_act_ff;
    logic [2:0] ctl_spare_ff;
    // fields captured at change start, and fields in effect
    logic [2:0] tgt_mode_ff;
    logic [3:0] tgt_part_ff;
    logic [4:0] tgt_dev_ff;
    logic [2:0] eff_mode_ff;
    logic [3:0] eff_part_ff;
    logic [4:0] eff_dev_ff;
    // interrupt enable and sticky event flags
    logic [1:0] irq_en_ff;
    logic [1:0] flags;
    logic [1:0] flag_clr;
    // bus write mask, merged data and register words
    logic [31:0] wmask;
    logic [31:0] wdata;
    logic [31:0] ctl_word;
    logic [31:0] sts_word;
    logic [31:0] nxt_prdata;
    // mode in effect and what it enables
    logic [2:0] cur_mode;
    logic [2:0] boot_mode;
    logic cur_oper;
    logic cur_down;
    // strap synchroniser and the settled strap values
    logic [7:0] strap_s1_ff;
    logic [7:0] strap_s2_ff;
    logic [7:0] strap_s3_ff;
    logic [7:0] strap_ff;
    logic [3:0] switch_mode;
    logic [3:0] port_num;
    // apb strobes
    logic wr_ctl;
    logic wr_sts;
    logic wr_en;
    logic wr_clr;
    logic mapped;
    logic access;
    logic setup;
    logic differs;

    // straps are pins outside the core clock domain; the chain is not reset
    // so it keeps sampling while reset loads the fields from its output
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            strap_s1_ff <= {i_boot_switch_mode, i_port_number};
            strap_s2_ff <= strap_s1_ff;
            strap_s3_ff <= strap_s2_ff;
        end
    end

    // a strap change counts only once the second and third flops agree,
    // so a value caught mid-transition never reaches the reset fields
    always_ff @(posedge i_clk) begin
        if (i_ce && strap_s2_ff == strap_s3_ff) begin
            strap_ff <= strap_s3_ff;
        end
    end

    assign switch_mode = strap_ff[7:4];
    assign port_num = strap_ff[3:0];

    // boot switch mode to initial port mode; single partition codes make
    // port 0 the upstream port, the multi partition codes leave ports free
    always_comb begin
        case (switch_mode)
            4'h0: boot_mode = (port_num == 4'h0) ? SPMC_MODE_UPSTREAM
                                                 : SPMC_MODE_DOWNSTREAM;
            4'h1: boot_mode = SPMC_MODE_UNATTACHED;
            4'h2: boot_mode = (port_num == 4'h0) ? SPMC_MODE_UP_NT
                                                 : SPMC_MODE_DOWNSTREAM;
            default: boot_mode = SPMC_MODE_DISABLED;
        endcase
    end

    // apb decode; zero wait state, so pready is always high
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign mapped = (i_paddr == `SPMC_OFF_CTL) || (i_paddr == `SPMC_OFF_STS) ||
                    (i_paddr == `SPMC_OFF_IRQ_EN) || (i_paddr == `SPMC_OFF_IRQ_CLR);
    assign o_pready = 1'b1;
    assign o_pslverr = access && !mapped;
    assign wr_en = access && i_pwrite && mapped;
    assign wr_ctl = wr_en && (i_paddr == `SPMC_OFF_CTL);
    assign wr_sts = wr_en && (i_paddr == `SPMC_OFF_STS);
    assign wr_clr = wr_en && (i_paddr == `SPMC_OFF_IRQ_CLR);

    // byte lane mask merged with the current control word
    assign wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
    assign wdata = (i_pwdata & wmask) | (ctl_word & ~wmask);

    // control word as read; reserved read-only bits are tied low
    always_comb begin
        ctl_word = 32'h0000_0000; // RULE_15
        ctl_word[`SPMC_CTL_MODE_LSB +: 3] = ctl_mode_ff;
        ctl_word[`SPMC_CTL_PART_LSB +: 4] = ctl_part_ff;
        ctl_word[`SPMC_CTL_DEV_LSB +: 5] = ctl_dev_ff;
        ctl_word[`SPMC_CTL_ACT_LSB +: 2] = ctl_act_ff;
        ctl_word[`SPMC_CTL_SPARE_LSB +: 3] = ctl_spare_ff;
    end

    // mode in effect, forced to disabled while the partition is off
    assign cur_mode = i_partition_disabled ? SPMC_MODE_DISABLED : eff_mode_ff; // RULE_13

    // only the four operational modes join a partition, only downstream
    // ports carry a device number; otherwise those fields are ignored
    assign cur_oper = (cur_mode >= SPMC_MODE_DOWNSTREAM) &&
                      (cur_mode <= SPMC_MODE_UP_NT); // RULE_03 RULE_04
    assign cur_down = (cur_mode == SPMC_MODE_DOWNSTREAM); // RULE_05 RULE_06

    // status word; link mode bit is not modelled and reads zero
    always_comb begin
        sts_word = 32'h0000_0000; // RULE_15
        sts_word[`SPMC_STS_STARTED] = flags[0];
        sts_word[`SPMC_STS_DONE] = flags[1];
        sts_word[`SPMC_STS_LINK_UP] = i_link_up;
        sts_word[`SPMC_STS_MODE_LSB +: 3] = cur_mode; // RULE_13
        sts_word[`SPMC_STS_PART_LSB +: 4] = eff_part_ff;
        sts_word[`SPMC_STS_DEV_LSB +: 5] = eff_dev_ff;
    end

    // read mux, sampled in the setup cycle so data is a flop in access
    always_comb begin
        case (i_paddr)
            `SPMC_OFF_CTL: nxt_prdata = ctl_word;
            `SPMC_OFF_STS: nxt_prdata = sts_word;
            `SPMC_OFF_IRQ_EN: nxt_prdata = {30'h0000_0000, irq_en_ff};
            default: nxt_prdata = 32'h0000_0000; // clear register is write-only
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_ce && setup && !i_pwrite) begin
            o_prdata <= nxt_prdata;
        end
    end

    // control fields; mode and device number reset values come from the straps, the other fields reset to constants
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctl_mode_ff <= boot_mode; // RULE_02
            ctl_part_ff <= `SPMC_PART_RESET_VAL;
            ctl_dev_ff <= {1'b0, port_num}; // RULE_07
            ctl_act_ff <= `SPMC_ACT_RESET_VAL; // RULE_10
            ctl_spare_ff <= 3'h0;
        end else if (i_ce && wr_ctl) begin
            // reserved mode codes are dropped so the port never runs one
            if (wdata[`SPMC_CTL_MODE_LSB +: 3] <= SPMC_MODE_UNATTACHED) begin
                ctl_mode_ff <= wdata[`SPMC_CTL_MODE_LSB +: 3]; // RULE_01
            end
            ctl_part_ff <= wdata[`SPMC_CTL_PART_LSB +: 4];
            ctl_dev_ff <= wdata[`SPMC_CTL_DEV_LSB +: 5];
            ctl_act_ff <= wdata[`SPMC_CTL_ACT_LSB +: 2];
            ctl_spare_ff <= wdata[`SPMC_CTL_SPARE_LSB +: 3];
        end
    end

    // a change is any difference between control and the applied fields;
    // comparing against the applied copy also catches writes made mid-change
    assign differs = (ctl_mode_ff != eff_mode_ff) || (ctl_part_ff != eff_part_ff) ||
                     (ctl_dev_ff != eff_dev_ff);
    assign chg.start = differs && !chg.busy; // RULE_14
    assign chg.use_reset = (ctl_act_ff == SPMC_ACT_RESET); // RULE_08 RULE_09

    // capture the target at start so the applied set is self-consistent
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tgt_mode_ff <= boot_mode;
            tgt_part_ff <= `SPMC_PART_RESET_VAL;
            tgt_dev_ff <= {1'b0, port_num};
        end else if (i_ce && chg.start) begin
            tgt_mode_ff <= ctl_mode_ff;
            tgt_part_ff <= ctl_part_ff;
            tgt_dev_ff <= ctl_dev_ff;
        end
    end

    // applied fields move only at completion, so status lags control
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            eff_mode_ff <= boot_mode;
            eff_part_ff <= `SPMC_PART_RESET_VAL;
            eff_dev_ff <= {1'b0, port_num};
        end else if (i_ce && chg.done) begin
            eff_mode_ff <= tgt_mode_ff; // RULE_13
            eff_part_ff <= tgt_part_ff;
            eff_dev_ff <= tgt_dev_ff;
        end
    end

    // mode change sequencer, one change at a time
    spmc_seq u_seq (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .chg(chg.seq)
    );

    // port reset for the whole reset phase of a change with action 1
    assign o_port_reset = chg.port_reset; // RULE_08

    // outputs to the port: partition only counts in operational modes
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_port_mode <= SPMC_MODE_DISABLED;
            o_partition <= 4'h0;
            o_partition_valid <= 1'b0;
            o_device_number <= 5'h00;
            o_device_number_valid <= 1'b0;
        end else if (i_ce) begin
            o_port_mode <= cur_mode;
            o_partition_valid <= cur_oper; // RULE_03 RULE_04
            o_partition <= cur_oper ? eff_part_ff : 4'h0; // RULE_04
            o_device_number_valid <= cur_down; // RULE_05
            o_device_number <= cur_down ? eff_dev_ff : 5'h00; // RULE_06
        end
    end

    // write one to status bits or the clear register drops a flag
    assign flag_clr = (wr_sts ? (wdata[1:0] & wmask[1:0]) : 2'b00) |
                      (wr_clr ? (i_pwdata[1:0] & wmask[1:0]) : 2'b00);

    // sticky started and done flags; a set beats a clear in the same cycle
    spmc_evt u_evt (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_set({chg.done, chg.started}), // RULE_11 RULE_12
        .i_clr(flag_clr),
        .o_flags(flags)
    );

    // interrupt enable register; its bits sit in byte lane 0, so a write
    // without that lane leaves the enables as they were
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_en_ff <= 2'b00;
        end else if (i_ce && wr_en && i_paddr == `SPMC_OFF_IRQ_EN && i_pstrb[0]) begin
            irq_en_ff <= i_pwdata[1:0];
        end
    end

    // level interrupt straight from the sticky flags
    assign o_irq = |(flags & irq_en_ff);

endmodule // spmc_port_ctrl

//--- hw/spmc_seq.sv
// mode change sequencer: start, optional port reset, completion
// assumes start is only raised while busy is low
`include "spmc_defines.svh"

module spmc_seq
    import spmc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    spmc_chg_if.seq chg
);
    localparam logic [4:0] RST_LAST = 5'(`SPMC_RST_CYC - 1);

    spmc_seq_t state_ff;
    logic [4:0] cnt_ff;
    logic rst_sel_ff;

    // state walk; a reset change holds the port in reset for the full count
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_ff <= SPMC_SEQ_IDLE;
        end else if (i_ce) begin
            case (state_ff)
                SPMC_SEQ_IDLE: if (chg.start) state_ff <= SPMC_SEQ_START;
                SPMC_SEQ_START: state_ff <= rst_sel_ff ? SPMC_SEQ_RESET : SPMC_SEQ_DONE;
                SPMC_SEQ_RESET: if (cnt_ff == RST_LAST) state_ff <= SPMC_SEQ_DONE;
                SPMC_SEQ_DONE: state_ff <= SPMC_SEQ_IDLE;
                default: state_ff <= SPMC_SEQ_IDLE;
            endcase
        end
    end

    // action is latched at start so a later write cannot cut the sequence
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rst_sel_ff <= 1'b0;
        end else if (i_ce && state_ff == SPMC_SEQ_IDLE && chg.start) begin
            rst_sel_ff <= chg.use_reset;
        end
    end

    // reset length counter
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_ff <= 5'h00;
        end else if (i_ce) begin
            cnt_ff <= (state_ff == SPMC_SEQ_RESET) ? cnt_ff + 5'h01 : 5'h00;
        end
    end

    assign chg.busy = (state_ff != SPMC_SEQ_IDLE);
    assign chg.started = (state_ff == SPMC_SEQ_START);
    assign chg.done = (state_ff == SPMC_SEQ_DONE);
    assign chg.port_reset = (state_ff == SPMC_SEQ_RESET);
endmodule // spmc_seq

//--- verification/spmc_port_ctrl_assertions.sv
// checker for the port mode block: output coherence, reset pulse, read masks
// assumes it is bound to spmc_port_ctrl and sees only its ports
module spmc_port_ctrl_chk (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic i_partition_disabled,
    input wire logic [2:0] o_port_mode,
    input wire logic [3:0] o_partition,
    input wire logic o_partition_valid,
    input wire logic [4:0] o_device_number,
    input wire logic o_device_number_valid,
    input wire logic o_port_reset
);
    logic [4:0] rst_cnt_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // length of the running port reset pulse; saturates so a stuck pulse still fails
    always_ff @(posedge i_clk) begin
        if (i_reset || !o_port_reset) begin
            rst_cnt_ff <= 5'h0;
        end else if (rst_cnt_ff != 5'h1F) begin
            rst_cnt_ff <= rst_cnt_ff + 5'h1;
        end
    end

    sequence s_rd;
        i_psel && i_penable && !i_pwrite;
    endsequence
    sequence s_rst_end;
        o_port_reset ##1 !o_port_reset;
    endsequence

    property p_part_valid;
        o_partition_valid == (o_port_mode inside {3'h1, 3'h2, 3'h3, 3'h4});
    endproperty
    property p_part_zero;
        !o_partition_valid |-> o_partition == 4'h0;
    endproperty
    property p_dev_valid;
        o_device_number_valid == (o_port_mode == 3'h1);
    endproperty
    property p_dev_zero;
        !o_device_number_valid |-> o_device_number == 5'h0;
    endproperty
    property p_rst_len;
        s_rst_end |-> rst_cnt_ff == 5'h14;
    endproperty
    property p_rst_max;
        rst_cnt_ff <= 5'h14;
    endproperty
    property p_pdis;
        i_partition_disabled [*3] |-> o_port_mode == 3'h0;
    endproperty
    property p_ctl_rsvd;
        s_rd ##0 (i_paddr == 8'h00) |-> (o_prdata & 32'hFFC4_8308) == 32'h0000_0000;
    endproperty
    property p_sts_rsvd;
        s_rd ##0 (i_paddr == 8'h04) |-> (o_prdata & 32'hFFE0_C20C) == 32'h0000_0000;
    endproperty
    property p_slverr;
        o_pslverr == (i_psel && i_penable && (i_paddr[1:0] != 2'h0 || i_paddr > 8'h0C));
    endproperty

    a_part_valid: assert property (p_part_valid) else $error("partition valid wrong");
    a_part_zero: assert property (p_part_zero) else $error("partition not zeroed");
    a_dev_valid: assert property (p_dev_valid) else $error("port_device_number valid wrong");
    a_dev_zero: assert property (p_dev_zero) else $error("port_device_number not zeroed");
    a_rst_len: assert property (p_rst_len) else $error("port reset length wrong");
    a_rst_max: assert property (p_rst_max) else $error("port reset too long");
    a_pdis: assert property (p_pdis) else $error("disabled partition not shown");
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved bits set");
    a_sts_rsvd: assert property (p_sts_rsvd) else $error("status reserved bits set");
    a_slverr: assert property (p_slverr) else $error("slave error wrong");
endmodule // spmc_port_ctrl_chk

//--- verification/spmc_port_ctrl_tb.sv
// self-checking bench for the port mode block over apb
// assumes spmc_port_ctrl from hw/ and the checker file compiled before it
module spmc_port_ctrl_tb import spmc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0, i_reset = 1, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [3:0] i_pstrb = 4'hF, i_boot_switch_mode = 4'h0, i_port_number = 4'h0;
    logic i_link_up = 0, i_partition_disabled = 0;
    logic [31:0] o_prdata, rd;
    logic o_pready, o_pslverr, o_partition_valid, o_device_number_valid, o_port_reset, o_irq, er;
    logic [2:0] o_port_mode;
    logic [3:0] o_partition, pn, part;
    logic [4:0] o_device_number, dev;
    int error_cnt = 0, num_checks = 0, seed = 90, n;

    always #25 i_clk = ~i_clk;

    spmc_port_ctrl spmc_port_ctrl_inst (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_boot_switch_mode(i_boot_switch_mode),
        .i_port_number(i_port_number), .i_link_up(i_link_up),
        .i_partition_disabled(i_partition_disabled), .o_port_mode(o_port_mode),
        .o_partition(o_partition), .o_partition_valid(o_partition_valid),
        .o_device_number(o_device_number), .o_device_number_valid(o_device_number_valid),
        .o_port_reset(o_port_reset), .o_irq(o_irq));

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; waits for pready however long the slave takes
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task rst(input logic [3:0] sm);
        @(posedge i_clk);
        i_boot_switch_mode <= sm;
        i_port_number <= pn;
        i_reset <= 1'b1;
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
    endtask

    // bounded wait for the applied mode to show at the outputs
    task wait_mode(input logic [2:0] m);
        n = 0;
        while (o_port_mode !== m && n < 200) begin
            @(posedge i_clk);
            n++;
        end
        chk("mode_out", m, o_port_mode);
    endtask

    // mode expected straight out of reset for a boot switch mode and port
    function automatic logic [2:0] bmode(input logic [3:0] sm, input logic [3:0] p);
        case (sm)
            4'h0: return (p == 4'h0) ? 3'h2 : 3'h1;
            4'h1: return 3'h5;
            4'h2: return (p == 4'h0) ? 3'h4 : 3'h1;
            default: return 3'h0;
        endcase
    endfunction

    task results;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // roughly 170 times the length of the sequence below
    initial begin
        #2_000_000;
        error_cnt++;
        results;
    end

    initial begin
        // boot switch modes 0 to 4; port 0 forced for mode 0 only, a random port otherwise
        for (int sm = 0; sm < 5; sm++) begin
            pn = (sm == 0) ? 4'h0 : 4'($random(seed));
            rst(4'(sm));
            repeat (2) @(posedge i_clk);
            #1;
            chk("boot_mode", bmode(4'(sm), pn), o_port_mode);
            apb(0, 8'h00, 32'h0000_0000);
            chk("ctl_reset", {14'h0, 2'h1, 2'h0, pn, 7'h0, bmode(4'(sm), pn)}, rd);
            apb(0, 8'h04, 32'h0000_0000);
            chk("sts_reset", {23'h0, bmode(4'(sm), pn), 1'b0, i_link_up, 4'h0}, rd & 32'h0000_01FF);
            i_link_up <= ~i_link_up;
        end
        $display("test done: reset values");
        apb(1, 8'h08, 32'h0000_0003);
        part = 4'($random(seed));
        dev = 5'($random(seed));
        apb(1, 8'h00, {14'h0, 2'h1, 1'b0, dev, 2'h0, part, 1'b0, 3'h1});
        n = 0;
        while (o_port_reset !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        n = 0;
        while (o_port_reset === 1'b1 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        chk("reset_len", 20, n);
        wait_mode(3'h1);
        chk("dev_out", dev, o_device_number);
        chk("part_out", part, o_partition);
        apb(0, 8'h04, 32'h0000_0000);
        chk("sts_chg", {11'h0, dev, 2'h0, part, 1'b0, 3'h1, 1'b0, i_link_up, 4'h3}, rd);
        chk("irq_on", 1, o_irq);
        apb(1, 8'h08, 32'h0000_0000);
        #1;
        chk("irq_mask", 0, o_irq);
        apb(1, 8'h0C, 32'h0000_0001);
        apb(0, 8'h04, 32'h0000_0000);
        chk("clr_started", 2'h2, rd[1:0]);
        apb(1, 8'h04, 32'h0000_0002);
        apb(0, 8'h04, 32'h0000_0000);
        chk("clr_done", 2'h0, rd[1:0]);
        $display("test done: change with port reset");
        // preserve state: no reset pulse may appear
        apb(1, 8'h00, {14'h0, 2'h0, 1'b0, dev, 2'h0, part, 1'b0, 3'h2});
        n = 0;
        repeat (40) begin
            @(posedge i_clk);
            n += int'(o_port_reset !== 1'b0);
        end
        chk("no_reset", 0, n);
        chk("up_mode", 3'h2, o_port_mode);
        chk("dev_ignored", 0, o_device_number_valid);
        apb(1, 8'h00, {14'h0, 2'h0, 1'b0, dev, 2'h0, part, 1'b0, 3'h3});
        wait_mode(3'h3);
        chk("nt_part", part, o_partition);
        apb(1, 8'h00, {14'h0, 2'h0, 1'b0, dev, 2'h0, part, 1'b0, 3'h5});
        wait_mode(3'h5);
        chk("part_ignored", 0, o_partition_valid);
        apb(1, 8'h00, {14'h0, 2'h0, 1'b0, dev, 2'h0, part, 1'b0, 3'h6});
        apb(0, 8'h00, 32'h0000_0000);
        chk("rsvd_mode", 3'h5, rd[2:0]);
        $display("test done: preserve and reserved");
        // clock enable low: the write is ignored
        i_ce <= 1'b0;
        apb(1, 8'h00, {14'h0, 2'h0, 1'b0, dev, 2'h0, part, 1'b0, 3'h1});
        i_ce <= 1'b1;
        apb(0, 8'h00, 32'h0000_0000);
        chk("ce_off", 3'h5, rd[2:0]);
        apb(0, 8'h10, 32'h0000_0000);
        chk("slverr", 1, er);
        chk("unmapped_rd", 0, rd);
        i_partition_disabled <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk("pdis_mode", 3'h0, o_port_mode);
        i_partition_disabled <= 1'b0;
        $display("test done: enable, unmapped, partition");
        results;
    end
endmodule // spmc_port_ctrl_tb

bind spmc_port_ctrl spmc_port_ctrl_chk spmc_port_ctrl_chk_inst (.i_clk(i_clk),
    .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_partition_disabled(i_partition_disabled), .o_port_mode(o_port_mode),
    .o_partition(o_partition), .o_partition_valid(o_partition_valid),
    .o_device_number(o_device_number), .o_device_number_valid(o_device_number_valid),
    .o_port_reset(o_port_reset));
